/* hdl/hash_service_demo_controller.v */
/*
  Hash-service demo controller: drives the service core's user port,
  builds counter or typed messages, captures the digest and prints it
  as hex text over a serial line. Serial commands or the start pin
  launch an operation.
  Assumes the service core shares clk_sys and sys_rst, answers svc_req
  with svc_ack, streams digest words before pulsing svc_done.
*/
`timescale 1ns/1ps
`include "hash_demo_map.vh"
module hash_service_demo_controller #(
  parameter BAUD_DIV = `BAUD_DIV
) (
  // Clock and reset, one source for all logic
  input wire clk_sys,
  input wire sys_rst,
  // Board inputs
  input wire start_pin,
  input wire [`SW_BITS-1:0] switch_in,
  // Serial terminal link
  input wire ser_rx,
  output wire ser_tx,
  // Service core user port
  output wire svc_req,
  input wire svc_ack,
  output wire [7:0] svc_cmd,
  output wire [`MSG_BITS-1:0] svc_msg,
  input wire svc_word_valid,
  input wire [31:0] svc_word,
  input wire svc_done,
  input wire [7:0] svc_cmd_echo,
  input wire [7:0] svc_status,
  // Status view
  output wire busy,
  output wire [7:0] last_status,
  output wire stat_ok,
  output wire stat_bus_err,
  output wire stat_no_lic,
  output wire stat_disabled,
  output wire stat_cmd_err
);

  localparam ST_IDLE = 3'h0;
  localparam ST_REQ = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_PRINT = 3'h3;
  localparam ST_CR = 3'h4;
  localparam ST_LF = 3'h5;
  localparam [15:0] BIT_TICKS = BAUD_DIV[15:0];
  localparam [15:0] HALF_TICKS = {1'b0, BIT_TICKS[15:1]};

  // Binary nibble to lower-case hex character
  function [7:0] hex_char;
    input [3:0] nib;
    begin
      if (nib < 4'hA)
        hex_char = `ASCII_ZERO + {4'h0, nib};
      else
        hex_char = `ASCII_A_OFS + {4'h0, nib};
    end
  endfunction

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] start_sync_ff;
  reg start_seen_ff;
  reg [`SW_BITS*2-1:0] sw_sync_ff;
  reg [1:0] rx_sync_ff;
  reg [`MSG_BITS-`SW_BITS-1:0] count_ff;
  reg [`MSG_BITS-1:0] msg_ff;
  reg [`MSG_BITS-1:0] typed_ff;
  reg [6:0] typed_cnt_ff;
  reg [`DIG_BITS-1:0] shadow_ff;
  reg [`DIG_BITS-1:0] digest_ff;
  reg [`DIG_BITS-1:0] prt_ff;
  reg [6:0] prt_left_ff;
  reg [7:0] status_ff;
  reg cmd_err_ff;
  reg [7:0] cmd_ff;
  // Receiver
  reg [15:0] rx_tick_ff;
  reg [3:0] rx_bit_ff;
  reg [7:0] rx_shift_ff;
  reg rx_busy_ff;
  reg rx_strobe_ff;
  reg [7:0] rx_byte_ff;
  // Transmitter
  reg [15:0] tx_tick_ff;
  reg [3:0] tx_bit_ff;
  reg [9:0] tx_shift_ff;
  reg tx_line_ff;
  reg ch_valid;
  reg [7:0] ch_data;
  wire ch_ready;
  wire tx_valid;
  wire [7:0] tx_data;
  wire tx_ready;
  wire start_rise;
  wire cr_cmd;
  wire launch;
  wire done_ok;

  // Outside pins pass two flops before any logic looks at them
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_sync_ff <= 2'h0;
      start_seen_ff <= 1'b0;
      sw_sync_ff <= {(`SW_BITS*2){1'b0}};
      rx_sync_ff <= 2'h3;
    end
    else
    begin
      start_sync_ff <= {start_sync_ff[0], start_pin};
      start_seen_ff <= start_sync_ff[1];
      sw_sync_ff <= {sw_sync_ff[`SW_BITS-1:0], switch_in};
      rx_sync_ff <= {rx_sync_ff[0], ser_rx};
    end
  end

  assign start_rise = start_sync_ff[1] && !start_seen_ff;
  assign cr_cmd = rx_strobe_ff && (rx_byte_ff == `CHAR_CR);
  // A launch outside idle is dropped: one request at a time
  assign launch = (state_ff == ST_IDLE) && (start_rise || cr_cmd);
  assign done_ok = (state_ff == ST_WAIT) && svc_done &&
                   (svc_status == `ST_OK) &&
                   (svc_cmd_echo == `CMD_HASH);

  // Service sequence
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (launch)
          nxt_state = ST_REQ;
      ST_REQ:
        if (svc_ack)
          nxt_state = ST_WAIT;
      ST_WAIT:
        if (svc_done)
          nxt_state = ST_PRINT;
      ST_PRINT:
        if (ch_ready && prt_left_ff == 7'h1)
          nxt_state = ST_CR;
      ST_CR:
        if (ch_ready)
          nxt_state = ST_LF;
      ST_LF:
        if (ch_ready)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // Characters offered to the output buffer
  always @*
  begin
    ch_valid = 1'b0;
    ch_data = 8'h00;
    case (state_ff)
      ST_PRINT:
      begin
        ch_valid = 1'b1;
        ch_data = hex_char(prt_ff[`DIG_BITS-1 -: 4]);
      end
      ST_CR:
      begin
        ch_valid = 1'b1;
        ch_data = `CHAR_CR;
      end
      ST_LF:
      begin
        ch_valid = 1'b1;
        ch_data = `CHAR_LF;
      end
      default:
      begin
        ch_valid = 1'b0;
        ch_data = 8'h00;
      end
    endcase
  end

  // Sequencer registers, message build and digest capture
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      count_ff <= {(`MSG_BITS-`SW_BITS){1'b0}};
      msg_ff <= {`MSG_BITS{1'b0}};
      typed_ff <= {`MSG_BITS{1'b0}};
      typed_cnt_ff <= 7'h00;
      shadow_ff <= {`DIG_BITS{1'b0}};
      digest_ff <= {`DIG_BITS{1'b0}};
      prt_ff <= {`DIG_BITS{1'b0}};
      prt_left_ff <= 7'h00;
      status_ff <= 8'h00;
      cmd_err_ff <= 1'b0;
      cmd_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      if (launch)
      begin
        cmd_ff <= `CMD_HASH;
        if (typed_cnt_ff != 7'h00)
          msg_ff <= typed_ff;
        else
          msg_ff <= {sw_sync_ff[`SW_BITS*2-1:`SW_BITS], count_ff};
        typed_ff <= {`MSG_BITS{1'b0}};
        typed_cnt_ff <= 7'h00;
      end
      else if (rx_strobe_ff && !cr_cmd && typed_cnt_ff < 7'h40)
      begin
        // First typed byte lands in the most significant byte
        typed_ff[10'h1FF - {typed_cnt_ff, 3'b000} -: 8] <= rx_byte_ff;
        typed_cnt_ff <= typed_cnt_ff + 7'h1;
      end
      // First word in ends up on top, keeping byte order
      if (state_ff == ST_WAIT && svc_word_valid)
        shadow_ff <= {shadow_ff[`DIG_BITS-33:0], svc_word};
      if (state_ff == ST_WAIT && svc_done)
      begin
        status_ff <= svc_status;
        cmd_err_ff <= (svc_cmd_echo != `CMD_HASH);
        count_ff <= count_ff + 1'b1;
        if (done_ok)
        begin
          digest_ff <= shadow_ff;
          prt_ff <= shadow_ff;
          prt_left_ff <= 7'h40;
        end
        else
        begin
          // Failure prints the status byte as two hex characters
          prt_ff <= {svc_status, {(`DIG_BITS-8){1'b0}}};
          prt_left_ff <= 7'h2;
        end
      end
      else if (state_ff == ST_PRINT && ch_ready)
      begin
        prt_ff <= {prt_ff[`DIG_BITS-5:0], 4'h0};
        prt_left_ff <= prt_left_ff - 7'h1;
      end
    end
  end

  // Serial receiver, 8N1, sampled mid-bit
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_tick_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_shift_ff <= 8'h00;
      rx_busy_ff <= 1'b0;
      rx_strobe_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end
    else
    begin
      rx_strobe_ff <= 1'b0;
      if (!rx_busy_ff)
      begin
        if (!rx_sync_ff[1])
        begin
          rx_busy_ff <= 1'b1;
          rx_tick_ff <= HALF_TICKS;
          rx_bit_ff <= 4'h0;
        end
      end
      else if (rx_tick_ff != 16'h0000)
        rx_tick_ff <= rx_tick_ff - 16'h0001;
      else
      begin
        rx_tick_ff <= BIT_TICKS - 16'h0001;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0 && rx_sync_ff[1])
          rx_busy_ff <= 1'b0; // Glitch, not a start bit
        else if (rx_bit_ff == 4'h9)
        begin
          rx_busy_ff <= 1'b0;
          // Frame without a valid stop bit is discarded
          if (rx_sync_ff[1])
          begin
            rx_strobe_ff <= 1'b1;
            rx_byte_ff <= rx_shift_ff;
          end
        end
        else if (rx_bit_ff != 4'h0)
          rx_shift_ff <= {rx_sync_ff[1], rx_shift_ff[7:1]};
      end
    end
  end

  // Buffer lets printing stall on the line without losing characters
  char_buffer #(
    .WIDTH(8)
  ) u_char_buffer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(ch_valid),
    .in_ready(ch_ready),
    .in_data(ch_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  assign tx_ready = (tx_bit_ff == 4'h0);

  // Serial transmitter, start bit, 8 data LSB first, one stop bit
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_tick_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_shift_ff <= 10'h3FF;
      tx_line_ff <= 1'b1;
    end
    else if (tx_bit_ff == 4'h0)
    begin
      tx_line_ff <= 1'b1;
      if (tx_valid)
      begin
        tx_shift_ff <= {1'b1, tx_data, 1'b0};
        // One count beyond the frame so the stop bit lasts a full bit
        tx_bit_ff <= 4'hB;
        tx_tick_ff <= 16'h0000;
      end
    end
    else if (tx_tick_ff != 16'h0000)
      tx_tick_ff <= tx_tick_ff - 16'h0001;
    else
    begin
      tx_line_ff <= tx_shift_ff[0];
      tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
      tx_tick_ff <= BIT_TICKS - 16'h0001;
      tx_bit_ff <= tx_bit_ff - 4'h1;
    end
  end

  // Outputs
  assign ser_tx = tx_line_ff;
  assign svc_req = (state_ff == ST_REQ);
  assign svc_cmd = cmd_ff;
  assign svc_msg = msg_ff;
  assign busy = (state_ff != ST_IDLE);
  assign last_status = status_ff;
  assign stat_ok = (status_ff == `ST_OK) && !cmd_err_ff;
  assign stat_bus_err = (status_ff == `ST_BUS_ERR);
  assign stat_no_lic = (status_ff == `ST_NO_LIC);
  assign stat_disabled = (status_ff == `ST_DIS_FACT) ||
                         (status_ff == `ST_DIS_USER);
  assign stat_cmd_err = cmd_err_ff;

endmodule // hash_service_demo_controller

/* hdl/hash_demo_map.vh */
/*
  Constants for the hash-service demo controller: message and digest
  sizes, service command and status codes, serial framing and timing.
  Assumes a single 250 MHz fabric clock and one shared reset source.
*/
`ifndef HASH_DEMO_MAP_VH
`define HASH_DEMO_MAP_VH

`define MSG_BITS 512
`define MSG_BYTES 64
`define DIG_BITS 256
`define DIG_CHARS 64
`define SW_BITS 4

`define CMD_HASH 8'h0A
`define ST_OK 8'h00
`define ST_BUS_ERR 8'h7F
`define ST_NO_LIC 8'hFD
`define ST_DIS_FACT 8'hFE
`define ST_DIS_USER 8'hFF

`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A
`define ASCII_ZERO 8'h30
`define ASCII_A_OFS 8'h57

`define CLK_HZ 250000000
`define BAUD_RATE 57600
`define BAUD_DIV (`CLK_HZ / `BAUD_RATE)

`endif

/* hdl/char_buffer.v */
/*
  Two-entry character buffer with valid/ready on both sides.
  Assumes producer and consumer on clk_sys; sys_rst asynchronous high.
*/
`timescale 1ns/1ps
module char_buffer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] slot0_ff;
  reg [WIDTH-1:0] slot1_ff;
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] count_ff;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign out_data = rd_ptr_ff ? slot1_ff : slot0_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage and pointers
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot0_ff <= {WIDTH{1'b0}};
      slot1_ff <= {WIDTH{1'b0}};
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      if (push && !wr_ptr_ff)
        slot0_ff <= in_data;
      if (push && wr_ptr_ff)
        slot1_ff <= in_data;
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop)
        count_ff <= count_ff + 2'h1;
      else if (pop && !push)
        count_ff <= count_ff - 2'h1;
    end
  end

endmodule // char_buffer

/* verif/hash_demo_asserts.sv */
/*
  Port checker for the hash demo controller.
  Assumes one clock domain and the async high reset of the top module.
*/
`timescale 1ns/1ps
module hash_demo_asserts (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Service port
  input wire svc_req,
  input wire svc_ack,
  input wire [7:0] svc_cmd,
  input wire [511:0] svc_msg,
  input wire svc_done,
  input wire [7:0] svc_cmd_echo,
  input wire [7:0] svc_status,
  // Status view
  input wire busy,
  input wire [7:0] last_status,
  input wire stat_ok,
  input wire stat_bus_err,
  input wire stat_no_lic,
  input wire stat_disabled,
  input wire stat_cmd_err
);
  // Single domain, so one clocking and one disable for all
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Request stands until ack, then drops next cycle
  req_hold_a: assert property (svc_req |=> svc_req == !$past(svc_ack))
    else $error("request level wrong around ack");
  cmd_code_a: assert property (svc_req |-> svc_cmd == 8'h0A)
    else $error("request with wrong command code");
  msg_hold_a: assert property (busy && $past(busy) |-> $stable(svc_msg))
    else $error("message changed during operation");
  req_launch_a: assert property ($rose(svc_req) |-> $rose(busy))
    else $error("request raised while already busy");
  status_take_a: assert property (svc_done && busy |=>
    last_status == $past(svc_status))
    else $error("status not captured on completion");
  echo_err_a: assert property (svc_done && busy |=>
    stat_cmd_err == ($past(svc_cmd_echo) != 8'h0A))
    else $error("echo check wrong");
  // Echo mismatch also counts as failure
  ok_decode_a: assert property (stat_ok ==
    (last_status == 8'h00 && !stat_cmd_err))
    else $error("success flag wrong");
  fail_decode_a: assert property ({stat_bus_err, stat_no_lic,
    stat_disabled} == {last_status == 8'h7F, last_status == 8'hFD,
    last_status >= 8'hFE})
    else $error("failure decode wrong");
endmodule // hash_demo_asserts

bind hash_service_demo_controller hash_demo_asserts u_chk (.clk_sys,
  .sys_rst, .svc_req, .svc_ack, .svc_cmd, .svc_msg, .svc_done, .svc_cmd_echo,
  .svc_status, .busy, .last_status, .stat_ok, .stat_bus_err, .stat_no_lic,
  .stat_disabled, .stat_cmd_err);

/* verif/svc_model.sv */
/*
  Behavioural service core: ack, eight digest words, done with status.
  Assumes bench sets status, echo and gap; digest is the inverted low
  half of the message so the bench can predict it.
*/
`timescale 1ns/1ps
module svc_model (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Request side
  input wire svc_req,
  input wire [511:0] svc_msg,
  // Bench controls
  input wire [7:0] rsp_status,
  input wire [7:0] rsp_echo,
  input wire [3:0] gap,
  // Answer side
  output reg svc_ack = 1'b0,
  output reg svc_word_valid = 1'b0,
  output reg [31:0] svc_word = 32'h0,
  output reg svc_done = 1'b0,
  output reg [7:0] svc_cmd_echo = 8'h0,
  output reg [7:0] svc_status = 8'h0
);
  integer i;
  // One operation per request; data lines scrambled outside their pulse
  always
  begin
    @(posedge clk_sys);
    if (svc_req && !sys_rst)
    begin
      repeat (gap) @(posedge clk_sys);
      svc_ack <= 1'b1;
      @(posedge clk_sys);
      svc_ack <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
        repeat (gap) @(posedge clk_sys);
        svc_word_valid <= 1'b1;
        svc_word <= ~svc_msg[255-32*i -: 32];
        @(posedge clk_sys);
        svc_word_valid <= 1'b0;
        svc_word <= ~svc_word;
      end
      svc_done <= 1'b1;
      svc_status <= rsp_status;
      svc_cmd_echo <= rsp_echo;
      @(posedge clk_sys);
      svc_done <= 1'b0;
      svc_status <= ~svc_status;
      svc_cmd_echo <= ~svc_cmd_echo;
    end
  end
endmodule // svc_model

/* verif/hash_service_demo_controller_tb_top.sv */
/*
  Self-checking bench for the hash demo controller.
  Assumes the service model at the far side and a short serial bit time.
*/
`timescale 1ns/1ps
module hash_service_demo_controller_tb_top;
  localparam BD = 16; // Short bit time keeps the run brief
  reg clk_sys = 1'b0;
  reg sys_rst = 1'b1;
  reg start_pin = 1'b0;
  reg [3:0] switch_in = 4'h0;
  reg ser_rx = 1'b1;
  reg [7:0] rsp_status = 8'h00;
  reg [7:0] rsp_echo = 8'h0A;
  reg [3:0] gap = 4'h2;
  wire ser_tx, svc_req, svc_ack, svc_word_valid, svc_done, busy;
  wire stat_ok, stat_bus_err, stat_no_lic, stat_disabled, stat_cmd_err;
  wire [7:0] svc_cmd, svc_cmd_echo, svc_status, last_status;
  wire [511:0] svc_msg;
  wire [31:0] svc_word;
  integer num_errors = 0;
  integer check_count = 0;
  reg [31:0] rnd = 32'h000125A4;
  reg [511:0] cnt = 512'h0;
  reg [7:0] rxq[$];
  reg [7:0] st_tab [0:4];
  integer j, k;

  hash_service_demo_controller #(.BAUD_DIV(BD)) u_dut (.clk_sys, .sys_rst,
    .start_pin, .switch_in, .ser_rx, .ser_tx, .svc_req, .svc_ack, .svc_cmd,
    .svc_msg, .svc_word_valid, .svc_word, .svc_done, .svc_cmd_echo,
    .svc_status, .busy, .last_status, .stat_ok, .stat_bus_err, .stat_no_lic,
    .stat_disabled, .stat_cmd_err);
  svc_model u_svc (.clk_sys, .sys_rst, .svc_req, .svc_msg, .rsp_status,
    .rsp_echo, .gap, .svc_ack, .svc_word_valid, .svc_word, .svc_done,
    .svc_cmd_echo, .svc_status);

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] hexc(input [3:0] n);
    hexc = (n < 4'hA) ? 8'h30 + n : 8'h57 + n;
  endfunction

  task chk_b(input [7:0] e, input [7:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      $display("unexpected %0t byte %h want %h", $time, g, e);
      num_errors = num_errors + 1;
    end
  endtask
  task chk_w(input [511:0] e, input [511:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      $display("unexpected %0t message %h", $time, g);
      num_errors = num_errors + 1;
    end
  endtask

  // Frame one byte onto the receive line, LSB first
  task send_byte(input [7:0] b);
    reg [9:0] f;
    integer m;
    begin
      f = {1'b1, b, 1'b0};
      for (m = 0; m < 10; m = m + 1)
      begin
        ser_rx <= f[m];
        repeat (BD) @(posedge clk_sys);
      end
    end
  endtask

  // Sample each transmitted frame mid-bit and queue it
  always
  begin : rx_mon
    reg [7:0] b;
    integer m;
    @(negedge ser_tx);
    repeat (BD / 2) @(posedge clk_sys);
    for (m = 0; m < 8; m = m + 1)
    begin
      repeat (BD) @(posedge clk_sys);
      b[m] = ser_tx;
    end
    repeat (BD) @(posedge clk_sys);
    chk_b(8'h01, {7'h0, ser_tx});
    rxq.push_back(b);
  end

  // One operation; a second start while busy must be ignored
  task run_op(input [511:0] em, input [7:0] st, input [7:0] ec, input ser);
    reg [255:0] ex;
    integer n, p;
    reg ok;
    begin
      rsp_status <= st;
      rsp_echo <= ec;
      rnd = lfsr_next(rnd);
      gap <= 4'h2 + rnd[2:0];
      rxq.delete();
      if (ser)
        send_byte(8'h0D);
      else
        start_pin <= 1'b1;
      k = 0;
      while (busy !== 1'b1 && k < 100)
      begin
        @(posedge clk_sys);
        k = k + 1;
      end
      chk_b(8'h01, {7'h0, busy});
      start_pin <= 1'b0;
      chk_w(em, svc_msg);
      repeat (3) @(posedge clk_sys);
      start_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      start_pin <= 1'b0;
      ok = (st == 8'h00) && (ec == 8'h0A);
      n = ok ? 66 : 4;
      ex = ok ? ~em[255:0] : {st, 248'h0};
      k = 0;
      while ((rxq.size() < n || busy !== 1'b0) && k < 20000)
      begin
        @(posedge clk_sys);
        k = k + 1;
      end
      chk_b(n[7:0], 8'(rxq.size()));
      for (p = 0; p < n - 2; p = p + 1)
        chk_b(hexc(ex[255-4*p -: 4]), rxq[p]);
      chk_b(8'h0D, rxq[n-2]);
      chk_b(8'h0A, rxq[n-1]);
      chk_b(st, last_status);
      chk_b({3'h0, ok, st == 8'h7F, st == 8'hFD, st >= 8'hFE,
        ec != 8'h0A}, {3'h0, stat_ok, stat_bus_err, stat_no_lic,
        stat_disabled, stat_cmd_err});
      cnt = cnt + 1;
    end
  endtask

  task end_of_test;
    begin
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Hang guard, well above the expected run length
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    $display("unexpected %0t watchdog expired", $time);
    num_errors = num_errors + 1;
    end_of_test;
  end

  // Every status code, an echo mismatch, random switches, typed text
  initial
  begin
    st_tab[0] = 8'h00;
    st_tab[1] = 8'h7F;
    st_tab[2] = 8'hFD;
    st_tab[3] = 8'hFE;
    st_tab[4] = 8'hFF;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (j = 0; j < 8; j = j + 1)
    begin
      rnd = lfsr_next(rnd);
      switch_in <= rnd[7:4];
      repeat (4) @(posedge clk_sys);
      run_op({rnd[7:4], cnt[507:0]}, (j < 5) ? st_tab[j] : 8'h00,
        (j == 5) ? 8'h0B : 8'h0A, 1'b0);
    end
    send_byte(8'h31);
    send_byte(8'h61);
    run_op({8'h31, 8'h61, 496'h0}, 8'h00, 8'h0A, 1'b1);
    end_of_test;
  end
endmodule // hash_service_demo_controller_tb_top
